// ### bench/pm_partner.sv
// power manager and peer converters on the shared ok line, plus the power-good wire
`timescale 1ns/100ps
module pm_partner #(
	parameter int PEERS    = 31,
	parameter int RESP_DLY = 3
) (
	input  wire logic core_clk,
	input  wire logic srst,
	input  wire logic dut_ok_oe,
	input  wire logic peer_pull,
	input  wire logic dut_good_oe,
	input  wire logic ext_good_pull,
	output logic      ok_line,
	output logic      good_line,
	output logic      other_ok_line
);
	// ==================== open-drain wires with pull-ups
	logic [4:0] low_cnt_reg;

	// any peer of the group pulling wins over the pull-up
	assign ok_line = !(dut_ok_oe || peer_pull);
	assign good_line = !(dut_good_oe || ext_good_pull);

	// ==================== cross-pull of the second supervised group
	// a slow manager reacts after RESP_DLY cycles; a prompt one uses 1
	always_ff @(posedge core_clk) begin
		if (srst || ok_line) begin
			low_cnt_reg <= 5'h00;
		end else if (low_cnt_reg != 5'h1F) begin
			low_cnt_reg <= low_cnt_reg + 5'h01;
		end
	end
	assign other_ok_line = (low_cnt_reg < 5'(RESP_DLY));
	// front-end off and crowbar on errors are optional and not modelled
endmodule

// ### bench/testbench.sv
// self-checking bench for the protection and fault manager
`timescale 1ns/100ps
module testbench;
	import pol_prot_pkg::*;
	localparam int HICC = 20;
	typedef struct {
		logic [MV_W-1:0]   v;
		logic              gl;
		logic [TEMP_W-1:0] t;
		logic              tcd;
		logic              good;
		logic              comp;
	} win_row_t;
	typedef struct {
		logic [MV_W-1:0]   v;
		logic [TEMP_W-1:0] t;
		logic              cl;
		logic              rmp;
		logic [REG_W-1:0]  ptc;
		logic [REG_W-1:0]  cfg;
		logic [4:0]        st;
		logic [3:0]        outs;
	} trip_row_t;

	logic                core_clk = 1'b0;
	logic                srst = 1'b1;
	logic [TEMP_W-1:0]   temp_c;
	logic [MV_W-1:0]     vout_mv, ramp_target_mv, prebias_mv;
	logic                steady_state, ramping_up, current_limiting, output_at_zero;
	logic                turn_on_cmd, good_low_limit_sel, tc_disable, cfg_we, status_clr_we, ce;
	logic [REG_W-1:0]    protection_type_config, cfg_wdata, status_clr_mask;
	logic [REG_W-1:0]    fault_propagation_config, protection_status_reg;
	logic                temp_warning_message, good_message, run_allow, regular_off_req;
	logic                fast_off_req, low_side_on, oc_temp_comp_on, output_good_pin_oe;
	logic                ok_pin_oe, peer_pull, ext_good_pull, ok_line, good_line, other_ok_line;
	logic [3:0]          pv;
	int                  n_fail, checks, n;

	// fast, regular, low side, ok pull per trip; status bits 5..1
	win_row_t win_rows [6] = '{
		'{14'h041A, 1'b0, 8'h1E, 1'b0, 1'b1, 1'b1},
		'{14'h047E, 1'b0, 8'h1E, 1'b1, 1'b0, 1'b0},
		'{14'h0398, 1'b0, 8'h14, 1'b0, 1'b1, 1'b0},
		'{14'h0398, 1'b1, 8'h1E, 1'b0, 1'b0, 1'b1},
		'{14'h0370, 1'b0, 8'h1E, 1'b1, 1'b0, 1'b0},
		'{14'h03C0, 1'b1, 8'h1E, 1'b0, 1'b1, 1'b1}};
	trip_row_t trip_rows [6] = '{
		'{14'h0578, 8'h1E, 1'b0, 1'b0, 8'h00, 8'hFF, 5'h1E, 4'b1011},
		'{14'h02BC, 8'h1E, 1'b1, 1'b0, 8'h00, 8'hFF, 5'h1B, 4'b1001},
		'{14'h02BC, 8'h1E, 1'b0, 1'b0, 8'h00, 8'hFB, 5'h1D, 4'b0100},
		'{14'h03E8, 8'h83, 1'b0, 1'b0, 8'h00, 8'hFF, 5'h17, 4'b0101},
		'{14'h0320, 8'h1E, 1'b0, 1'b1, 8'h00, 8'hFF, 5'h1F, 4'b0000},
		'{14'h0320, 8'h1E, 1'b0, 1'b1, 8'h80, 8'hFF, 5'h0F, 4'b1001}};
	logic [TEMP_W-1:0] tw [4] = '{8'h78, 8'h79, 8'h76, 8'h74};
	logic              twx [4] = '{1'b1, 1'b0, 1'b0, 1'b1};

	always #25 core_clk = ~core_clk;
	assign pv = {protection_status_reg[B_GOOD], fast_off_req, regular_off_req, run_allow};

	pol_fault_manager #(.HICCUP_CYC(HICC)) u_dut (.core_clk(core_clk), .srst(srst),
		.ce(ce), .temp_c(temp_c), .vout_mv(vout_mv), .setpoint_mv(14'h03E8),
		.ramp_target_mv(ramp_target_mv), .prebias_mv(prebias_mv), .steady_state(steady_state),
		.ramping_up(ramping_up), .current_limiting(current_limiting),
		.output_at_zero(output_at_zero), .turn_on_cmd(turn_on_cmd),
		.good_low_limit_sel(good_low_limit_sel), .uv_level_sel(2'h0), .ov_level_sel(2'h2),
		.tc_disable(tc_disable), .protection_type_config(protection_type_config),
		.cfg_we(cfg_we), .cfg_wdata(cfg_wdata),
		.fault_propagation_config(fault_propagation_config),
		.status_clr_we(status_clr_we), .status_clr_mask(status_clr_mask),
		.protection_status_reg(protection_status_reg),
		.temp_warning_message(temp_warning_message), .good_message(good_message),
		.run_allow(run_allow), .regular_off_req(regular_off_req),
		.fast_off_req(fast_off_req), .low_side_on(low_side_on),
		.oc_temp_comp_on(oc_temp_comp_on), .output_good_pin_i(good_line),
		.output_good_pin_o(), .output_good_pin_oe(output_good_pin_oe),
		.ok_pin_i(ok_line), .ok_pin_o(), .ok_pin_oe(ok_pin_oe));

	pm_partner u_pm (.core_clk(core_clk), .srst(srst), .dut_ok_oe(ok_pin_oe),
		.peer_pull(peer_pull), .dut_good_oe(output_good_pin_oe),
		.ext_good_pull(ext_good_pull), .ok_line(ok_line), .good_line(good_line),
		.other_ok_line(other_ok_line));

	// ==================== helpers
	task automatic print_verdict();
		if (n_fail == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
			n_fail++;
		end
	endtask

	// a wait that runs out ends the run at once
	task automatic wait_for(input int k, input logic v, input int lim);
		checks++;
		for (int i = 0; i < lim; i++) begin
			@(negedge core_clk);
			if (pv[k] === v) return;
		end
		$display("[FAIL] wait on %0d expected %b seen %b", k, v, pv[k]);
		n_fail++;
		print_verdict();
	endtask

	task automatic nominal();
		temp_c <= 8'h1E;
		vout_mv <= 14'h03E8;
		ramp_target_mv <= 14'h01F4;
		steady_state <= 1'b1;
		ramping_up <= 1'b0;
		current_limiting <= 1'b0;
		output_at_zero <= 1'b0;
		turn_on_cmd <= 1'b1;
		good_low_limit_sel <= 1'b0;
		tc_disable <= 1'b0;
		protection_type_config <= 8'h00;
		cfg_we <= 1'b0;
		cfg_wdata <= 8'h00;
		status_clr_we <= 1'b0;
		status_clr_mask <= 8'h00;
		peer_pull <= 1'b0;
		ext_good_pull <= 1'b0;
		ce <= 1'b1;
		prebias_mv <= 14'h0000;
	endtask

	// clearing all fault bits also releases a latched trip
	task automatic restore();
		@(posedge core_clk);
		nominal();
		@(posedge core_clk);
		output_at_zero <= 1'b1;
		status_clr_we <= 1'b1;
		status_clr_mask <= 8'h3E;
		wait_for(0, 1'b1, 80);
		@(posedge core_clk);
		nominal();
		@(posedge core_clk);
	endtask

	// ==================== main sequence
	initial begin
		n_fail = 0;
		checks = 0;
		nominal();
		repeat (19) @(posedge core_clk);
		@(negedge core_clk);
		chk("status_rst", STATUS_RESET, protection_status_reg);
		chk("cfg_rst", PROP_CFG_RESET, fault_propagation_config);
		chk("run_rst", 8'h01, 8'(run_allow));
		@(posedge core_clk);
		srst <= 1'b0;
		cfg_we <= 1'b1;
		cfg_wdata <= 8'hA5;
		@(posedge core_clk);
		cfg_wdata <= 8'hFF;
		@(negedge core_clk);
		chk("cfg_a5", 8'hA5, fault_propagation_config);
		@(posedge core_clk);
		cfg_we <= 1'b0;
		@(negedge core_clk);
		chk("cfg_ff", 8'hFF, fault_propagation_config);
		foreach (win_rows[i]) begin
			@(posedge core_clk);
			vout_mv <= win_rows[i].v;
			good_low_limit_sel <= win_rows[i].gl;
			temp_c <= win_rows[i].t;
			tc_disable <= win_rows[i].tcd;
			repeat (6) @(negedge core_clk);
			chk("good_bit", 8'(win_rows[i].good), 8'(protection_status_reg[B_GOOD]));
			chk("good_pin", 8'(!win_rows[i].good), 8'(output_good_pin_oe));
			chk("good_msg", 8'(!win_rows[i].good), 8'(good_message));
			chk("good_run", 8'h01, 8'(run_allow));
			chk("tc_comp", 8'(win_rows[i].comp), 8'(oc_temp_comp_on));
		end
		restore();
		foreach (tw[i]) begin
			@(posedge core_clk);
			temp_c <= tw[i];
			@(posedge core_clk);
			@(negedge core_clk);
			chk("temp_bit", 8'(twx[i]), 8'(protection_status_reg[B_TEMP]));
			chk("temp_msg", 8'(!twx[i]), 8'(temp_warning_message));
			chk("warn_run", 8'h01, 8'(run_allow));
		end
		restore();
		ext_good_pull <= 1'b1;
		wait_for(3, 1'b0, 8);
		chk("ext_msg", 8'h01, 8'(good_message));
		@(posedge core_clk);
		ext_good_pull <= 1'b0;
		steady_state <= 1'b0;
		@(negedge core_clk);
		@(negedge core_clk);
		chk("trans_pin", 8'h01, 8'(output_good_pin_oe));
		restore();
		foreach (trip_rows[i]) begin
			@(posedge core_clk);
			cfg_we <= 1'b1;
			cfg_wdata <= trip_rows[i].cfg;
			protection_type_config <= trip_rows[i].ptc;
			@(posedge core_clk);
			cfg_we <= 1'b0;
			vout_mv <= trip_rows[i].v;
			temp_c <= trip_rows[i].t;
			current_limiting <= trip_rows[i].cl;
			ramping_up <= trip_rows[i].rmp;
			steady_state <= !trip_rows[i].rmp;
			@(posedge core_clk);
			@(negedge core_clk);
			chk("trip_st", 8'(trip_rows[i].st), 8'(protection_status_reg[5:1]));
			chk("trip_outs", 8'(trip_rows[i].outs), 8'({pv[2:1], low_side_on, ok_pin_oe}));
			chk("trip_run", 8'(trip_rows[i].outs[3:2] == 2'b00), 8'(run_allow));
			restore();
		end
		@(posedge core_clk);
		vout_mv <= 14'h0578;
		@(posedge core_clk);
		vout_mv <= 14'h03E8;
		output_at_zero <= 1'b1;
		@(negedge core_clk);
		n = 0;
		while (run_allow !== 1'b1 && n < 40) begin
			@(negedge core_clk);
			n++;
		end
		chk("hiccup_len", 8'h01, 8'(n >= HICC && n <= HICC + 4));
		chk("ls_release", 8'h00, 8'(low_side_on));
		restore();
		temp_c <= 8'h83;
		@(posedge core_clk);
		@(posedge core_clk);
		temp_c <= 8'h77;
		output_at_zero <= 1'b1;
		wait_for(0, 1'b1, 8);
		restore();
		protection_type_config <= 8'h08;
		current_limiting <= 1'b1;
		vout_mv <= 14'h02BC;
		@(posedge core_clk);
		@(posedge core_clk);
		current_limiting <= 1'b0;
		vout_mv <= 14'h03E8;
		output_at_zero <= 1'b1;
		repeat (40) @(negedge core_clk);
		chk("latched", 8'h00, 8'(run_allow));
		@(posedge core_clk);
		status_clr_we <= 1'b1;
		status_clr_mask <= 8'h08;
		@(posedge core_clk);
		status_clr_we <= 1'b0;
		wait_for(0, 1'b1, 8);
		restore();
		prebias_mv <= 14'h0600;
		vout_mv <= 14'h0578;
		repeat (3) @(negedge core_clk);
		chk("prebias_ov", 8'h01, 8'(run_allow));
		@(posedge core_clk);
		prebias_mv <= 14'h0000;
		ce <= 1'b0;
		repeat (3) @(negedge core_clk);
		chk("ce_hold", 8'h01, 8'(run_allow));
		restore();
		peer_pull <= 1'b1;
		wait_for(1, 1'b1, 8);
		@(negedge core_clk);
		chk("cross_pull", 8'h00, 8'(other_ok_line));
		restore();
		print_verdict();
	end
endmodule

// ### shared/hiccup_if.sv
// handshake between the fault sequencer and the restart interval timer
`timescale 1ns/100ps
interface hiccup_if;
	logic start;
	logic busy;
	logic done;
	modport timer (input start, output busy, output done);
	modport ctrl  (output start, input busy, input done);
endinterface

// ### shared/pol_prot_pkg.sv
// constants, types and helpers shared by the protection and fault manager
package pol_prot_pkg;

	// ==================== widths
	localparam int MV_W   = 14;
	localparam int TEMP_W = 8;
	localparam int REG_W  = 8;
	localparam int IDX_W  = 3;

	// ==================== temperatures in degrees C (120, 117, 130, 25)
	localparam logic [TEMP_W-1:0] TEMP_WARN_ON_C  = 8'h78;
	localparam logic [TEMP_W-1:0] TEMP_WARN_OFF_C = 8'h75;
	localparam logic [TEMP_W-1:0] TEMP_OT_C       = 8'h82;
	localparam logic [TEMP_W-1:0] TEMP_ROOM_C     = 8'h19;

	// ==================== percentages of setpoint
	localparam logic [7:0] PG_HIGH_PCT  = 8'h6E; // 110
	localparam logic [7:0] PG_LOW90_PCT = 8'h5A; // 90
	localparam logic [7:0] PG_LOW95_PCT = 8'h5F; // 95
	localparam logic [7:0] UV75_PCT     = 8'h4B;
	localparam logic [7:0] UV80_PCT     = 8'h50;
	localparam logic [7:0] UV85_PCT     = 8'h55;
	localparam logic [7:0] OV110_PCT    = 8'h6E;
	localparam logic [7:0] OV120_PCT    = 8'h78;
	localparam logic [7:0] OV130_PCT    = 8'h82;

	// ==================== voltages in mV (250, 1000)
	localparam logic [MV_W-1:0] TRACK_LIMIT_MV = 14'h00FA;
	localparam logic [MV_W-1:0] OV_FLOOR_MV    = 14'h03E8;

	// ==================== timing: 130 ms hiccup at 20 MHz
	localparam int unsigned HICCUP_MS     = 32'h0000_0082;
	localparam int unsigned CLK_HZ        = 32'h0131_2D00;
	localparam int unsigned HICCUP_CYCLES = HICCUP_MS * (CLK_HZ / 32'h0000_03E8);

	// ==================== bit positions, shared by status, propagation and type bytes
	localparam int B_TEMP  = 7;
	localparam int B_GOOD  = 6;
	localparam int B_TRACK = 5;
	localparam int B_OT    = 4;
	localparam int B_OC    = 3;
	localparam int B_UV    = 2;
	localparam int B_OV    = 1;
	localparam int B_PHASE = 0;
	localparam int B_TRACK_EN = 7; // in the protection type byte

	// ==================== reset values
	localparam logic [REG_W-1:0] PROP_CFG_RESET = 8'h3F;
	localparam logic [REG_W-1:0] STATUS_RESET   = 8'hFF;
	localparam logic [IDX_W-1:0] CAUSE_PEER     = 3'h0;

	typedef enum logic [1:0] {
		ST_RUN      = 2'b00,
		ST_OFF_WAIT = 2'b01,
		ST_HICCUP   = 2'b10,
		ST_LATCHED  = 2'b11
	} prot_state_t;

	function automatic logic [MV_W-1:0] pct_of(input logic [MV_W-1:0] v, input logic [7:0] pct);
		logic [21:0] p;
		p = 22'(v) * 22'(pct);
		return MV_W'(p / 22'h00_0064);
	endfunction

endpackage

// ### src/hiccup_timer.sv
// restart interval timer: one start loads the count, done pulses at its end
`timescale 1ns/100ps
module hiccup_timer #(
	parameter int unsigned CYCLES = pol_prot_pkg::HICCUP_CYCLES
) (
	input  wire logic core_clk,
	input  wire logic srst,
	input  wire logic ce,
	hiccup_if.timer   hic
);
	import pol_prot_pkg::*;

	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LOAD = CW'(CYCLES);
	localparam logic [CW-1:0] ONE  = CW'(1);

	logic [CW-1:0] count_reg;
	logic [CW-1:0] count_next;

	// a start while running restarts the interval from the top
	always_comb begin
		count_next = count_reg;
		if (hic.start) begin
			count_next = LOAD;
		end else if (count_reg != '0) begin
			count_next = count_reg - ONE;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			count_reg <= '0;
		end else if (ce) begin
			count_reg <= count_next;
		end
	end

	assign hic.busy = (count_reg != '0);
	assign hic.done = ce && (count_reg == ONE) && !hic.start;

endmodule

// ### src/pol_fault_manager.sv
// protection and fault manager of a point-of-load converter
`timescale 1ns/100ps

// Behaviour
// - above 120 C raise temperature warning; warning never turns output off
// - warning drives its status bit 0; message out when message bit set
// - warning clears only below 117 C
// - output good between 110% and selectable 90 or 95% of setpoint
// - good window judged in steady state; good pin low during transitions
// - outside window pull good pin low, bit 0, message; restore inside
// - external low on good pin counts as a power-good warning
// - overcurrent armed above prebias; trips when limiting below undervoltage level
// - overcurrent turns both switches off at once
// - overcurrent threshold temperature compensation unless disabled
// - undervoltage armed in steady state, no overcurrent; ramped turn-off
// - above 130 C overtemperature fault, status 0, ramped turn-off
// - non-latching overtemperature restarts once below 120 C
// - during ramp-up tracking error over 250 mV is a fast-off fault
// - tracking check skipped when tracking enable bit is clear
// - overvoltage above prebias: status 0, high side off, low side on
// - overvoltage threshold 110 to 130% of setpoint, never below 1.0 V
// - propagation enabled: pull OK low; OK seen low starts turn-off
// - propagation byte: 7 temp msg, 6 good msg, 5..0 propagation enables
// - non-latching retries every 130 ms; latching waits for clear or recycle
// - low limit select: 1 gives 95%, 0 gives 90%, resets to 90%
// - propagated faults regular off; errors fast off, low side on for overvoltage only
module pol_fault_manager #(
	parameter int unsigned HICCUP_CYC = pol_prot_pkg::HICCUP_CYCLES
) (
	input  wire logic                           core_clk,
	input  wire logic                           srst,
	input  wire logic                           ce,
	input  wire logic [pol_prot_pkg::TEMP_W-1:0] temp_c,
	input  wire logic [pol_prot_pkg::MV_W-1:0]   vout_mv,
	input  wire logic [pol_prot_pkg::MV_W-1:0]   setpoint_mv,
	input  wire logic [pol_prot_pkg::MV_W-1:0]   ramp_target_mv,
	input  wire logic [pol_prot_pkg::MV_W-1:0]   prebias_mv,
	input  wire logic                           steady_state,
	input  wire logic                           ramping_up,
	input  wire logic                           current_limiting,
	input  wire logic                           output_at_zero,
	input  wire logic                           turn_on_cmd,
	input  wire logic                           good_low_limit_sel,
	input  wire logic [1:0]                     uv_level_sel,
	input  wire logic [1:0]                     ov_level_sel,
	input  wire logic                           tc_disable,
	input  wire logic [pol_prot_pkg::REG_W-1:0]  protection_type_config,
	input  wire logic                           cfg_we,
	input  wire logic [pol_prot_pkg::REG_W-1:0]  cfg_wdata,
	output logic      [pol_prot_pkg::REG_W-1:0]  fault_propagation_config,
	input  wire logic                           status_clr_we,
	input  wire logic [pol_prot_pkg::REG_W-1:0]  status_clr_mask,
	output logic      [pol_prot_pkg::REG_W-1:0]  protection_status_reg,
	output logic                                temp_warning_message,
	output logic                                good_message,
	output logic                                run_allow,
	output logic                                regular_off_req,
	output logic                                fast_off_req,
	output logic                                low_side_on,
	output logic                                oc_temp_comp_on,
	input  wire logic                           output_good_pin_i,
	output logic                                output_good_pin_o,
	output logic                                output_good_pin_oe,
	input  wire logic                           ok_pin_i,
	output logic                                ok_pin_o,
	output logic                                ok_pin_oe
);
	import pol_prot_pkg::*;

	// ==================== pin synchronisers
	logic [1:0] good_sync_reg;
	logic [1:0] ok_sync_reg;
	logic       good_pull_reg;
	logic       ok_drive_reg;
	logic [1:0] good_pull_d_reg;
	logic [1:0] ok_drive_d_reg;

	// our own pull reaches the synchronised pin two cycles late: mask it that long
	always_ff @(posedge core_clk) begin
		if (srst) begin
			good_sync_reg   <= 2'h3;
			ok_sync_reg     <= 2'h3;
			good_pull_d_reg <= 2'h3;
			ok_drive_d_reg  <= 2'h0;
		end else if (ce) begin
			good_sync_reg   <= {good_sync_reg[0], output_good_pin_i};
			ok_sync_reg     <= {ok_sync_reg[0], ok_pin_i};
			good_pull_d_reg <= {good_pull_d_reg[0], good_pull_reg};
			ok_drive_d_reg  <= {ok_drive_d_reg[0], ok_drive_reg};
		end
	end

	// ==================== thresholds
	logic [MV_W-1:0] pg_hi_mv;
	logic [MV_W-1:0] pg_lo_mv;
	logic [MV_W-1:0] uv_mv;
	logic [MV_W-1:0] ov_raw_mv;
	logic [MV_W-1:0] ov_mv;
	logic [MV_W-1:0] track_err_mv;
	logic [7:0]      uv_pct;
	logic [7:0]      ov_pct;

	always_comb begin
		uv_pct = (uv_level_sel == 2'h0) ? UV75_PCT :
		         (uv_level_sel == 2'h1) ? UV80_PCT : UV85_PCT;
		ov_pct = (ov_level_sel == 2'h0) ? OV110_PCT :
		         (ov_level_sel == 2'h1) ? OV120_PCT : OV130_PCT;
		pg_hi_mv  = pct_of(setpoint_mv, PG_HIGH_PCT);
		pg_lo_mv  = pct_of(setpoint_mv, good_low_limit_sel ? PG_LOW95_PCT : PG_LOW90_PCT);
		uv_mv     = pct_of(setpoint_mv, uv_pct);
		ov_raw_mv = pct_of(setpoint_mv, ov_pct);
		ov_mv     = (ov_raw_mv < OV_FLOOR_MV) ? OV_FLOOR_MV : ov_raw_mv;
		track_err_mv = (vout_mv > ramp_target_mv) ? (vout_mv - ramp_target_mv)
		                                          : (ramp_target_mv - vout_mv);
	end

	// compensation only matters above room temperature
	assign oc_temp_comp_on = !tc_disable && (temp_c > TEMP_ROOM_C);

	// ==================== event detection
	logic good_win_bad;
	logic temp_warn_reg;
	logic temp_warn_next;
	logic above_prebias;
	logic good_ext_low;
	logic ok_ext_low;
	logic good_warn;
	logic oc_evt;
	logic uv_evt;
	logic ot_evt;
	logic tr_evt;
	logic ov_evt;
	logic any_evt;

	always_comb begin
		above_prebias = vout_mv > prebias_mv;
		good_ext_low  = !good_sync_reg[1] && !good_pull_d_reg[1];
		ok_ext_low    = !ok_sync_reg[1] && !ok_drive_d_reg[1];
		good_win_bad  = steady_state && ((vout_mv > pg_hi_mv) || (vout_mv < pg_lo_mv));
		good_warn     = good_win_bad || (steady_state && good_ext_low);
		oc_evt = above_prebias && current_limiting && (vout_mv < uv_mv);
		uv_evt = steady_state && (vout_mv < uv_mv) && !oc_evt;
		ot_evt = temp_c > TEMP_OT_C;
		tr_evt = ramping_up && protection_type_config[B_TRACK_EN]
		         && (track_err_mv > TRACK_LIMIT_MV);
		ov_evt = above_prebias && (vout_mv > ov_mv);
		any_evt = oc_evt || uv_evt || ot_evt || tr_evt || ov_evt;
		temp_warn_next = temp_warn_reg;
		if (temp_c > TEMP_WARN_ON_C) begin
			temp_warn_next = 1'b1;
		end else if (temp_c < TEMP_WARN_OFF_C) begin
			temp_warn_next = 1'b0;
		end
	end

	// ==================== sequencer
	hiccup_if hic ();

	hiccup_timer #(
		.CYCLES (HICCUP_CYC)
	) u_timer (
		.core_clk (core_clk),
		.srst     (srst),
		.ce       (ce),
		.hic      (hic)
	);

	prot_state_t      state_reg;
	prot_state_t      state_next;
	logic [IDX_W-1:0] cause_reg;
	logic [IDX_W-1:0] cause_next;
	logic             fast_reg;
	logic             fast_next;
	logic             low_side_reg;
	logic             low_side_next;
	logic             relaunch_reg;
	logic             relaunch_next;
	logic             restart;
	logic             ok_drive_next;

	always_comb begin
		state_next    = state_reg;
		cause_next    = cause_reg;
		fast_next     = fast_reg;
		low_side_next = low_side_reg;
		relaunch_next = relaunch_reg;
		restart       = 1'b0;
		hic.start     = 1'b0;
		case (state_reg)
			ST_RUN: begin
				relaunch_next = 1'b0;
				if (ov_evt) begin
					state_next    = ST_OFF_WAIT;
					cause_next    = IDX_W'(B_OV);
					fast_next     = 1'b1;
					low_side_next = 1'b1;
				end else if (oc_evt || tr_evt) begin
					state_next = ST_OFF_WAIT;
					cause_next = oc_evt ? IDX_W'(B_OC) : IDX_W'(B_TRACK);
					fast_next  = 1'b1;
				end else if (ot_evt || uv_evt) begin
					state_next = ST_OFF_WAIT;
					cause_next = ot_evt ? IDX_W'(B_OT) : IDX_W'(B_UV);
					fast_next  = 1'b0;
				end else if (ok_ext_low) begin
					state_next = ST_OFF_WAIT;
					cause_next = CAUSE_PEER;
					fast_next  = 1'b0;
				end
			end
			ST_OFF_WAIT: begin
				// interval counts from the moment the output reaches zero
				if (output_at_zero) begin
					state_next    = ST_HICCUP;
					low_side_next = 1'b0;
					hic.start     = 1'b1;
				end
			end
			ST_HICCUP: begin
				if (cause_reg == IDX_W'(B_OT) && !protection_type_config[B_OT]
				    && temp_c < TEMP_WARN_ON_C) begin
					state_next = ST_RUN;
					restart    = 1'b1;
				end else if (hic.done) begin
					if (cause_reg != CAUSE_PEER && protection_type_config[cause_reg]) begin
						state_next = ST_LATCHED;
					end else if (cause_reg != IDX_W'(B_OT) && !(cause_reg == CAUSE_PEER
					             && ok_ext_low)) begin
						state_next = ST_RUN;
						restart    = 1'b1;
					end else if (cause_reg == CAUSE_PEER) begin
						hic.start = 1'b1;
					end
				end
			end
			ST_LATCHED: begin
				if (!turn_on_cmd) begin
					relaunch_next = 1'b1;
				end
				if ((relaunch_reg && turn_on_cmd)
				    || (protection_status_reg[cause_reg] && !any_evt)) begin
					state_next = ST_RUN;
					restart    = 1'b1;
				end
			end
			default: begin
				state_next = ST_RUN;
			end
		endcase
		ok_drive_next = (state_next != ST_RUN) && (cause_next != CAUSE_PEER)
		                && fault_propagation_config[cause_next];
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			state_reg    <= ST_RUN;
			cause_reg    <= CAUSE_PEER;
			fast_reg     <= 1'b0;
			low_side_reg <= 1'b0;
			relaunch_reg <= 1'b0;
			ok_drive_reg <= 1'b0;
		end else if (ce) begin
			state_reg    <= state_next;
			cause_reg    <= cause_next;
			fast_reg     <= fast_next;
			low_side_reg <= low_side_next;
			relaunch_reg <= relaunch_next;
			ok_drive_reg <= ok_drive_next;
		end
	end

	// ==================== status and configuration
	logic [REG_W-1:0] status_next;
	logic [REG_W-1:0] prop_cfg_next;
	logic [REG_W-1:0] evt_vec;
	logic             temp_msg_reg;
	logic             good_msg_reg;
	logic             good_pull_next;

	always_comb begin
		evt_vec = '0;
		evt_vec[B_TRACK] = tr_evt;
		evt_vec[B_OT]    = ot_evt;
		evt_vec[B_OC]    = oc_evt;
		evt_vec[B_UV]    = uv_evt;
		evt_vec[B_OV]    = ov_evt;
		status_next = protection_status_reg;
		for (int i = 0; i < REG_W; i++) begin
			// detection wins over a clear in the same cycle
			if (evt_vec[i]) begin
				status_next[i] = 1'b0;
			end else if ((status_clr_we && status_clr_mask[i])
			             || (restart && cause_reg == IDX_W'(i))) begin
				status_next[i] = 1'b1;
			end
		end
		status_next[B_TEMP]  = !temp_warn_next;
		status_next[B_GOOD]  = !good_warn;
		status_next[B_PHASE] = 1'b1;
		prop_cfg_next = cfg_we ? cfg_wdata : fault_propagation_config;
		// an external low alone must not make us pull, or we would hold the line ourselves
		good_pull_next = !steady_state || good_win_bad || (state_reg != ST_RUN);
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			protection_status_reg    <= STATUS_RESET;
			fault_propagation_config <= PROP_CFG_RESET;
			temp_warn_reg            <= 1'b0;
			temp_msg_reg             <= 1'b0;
			good_msg_reg             <= 1'b0;
			good_pull_reg            <= 1'b1;
		end else if (ce) begin
			protection_status_reg    <= status_next;
			fault_propagation_config <= prop_cfg_next;
			temp_warn_reg            <= temp_warn_next;
			temp_msg_reg             <= temp_warn_next && fault_propagation_config[B_TEMP];
			good_msg_reg             <= good_warn && fault_propagation_config[B_GOOD];
			good_pull_reg            <= good_pull_next;
		end
	end

	// ==================== outputs
	// a warning alone never touches run_allow
	assign run_allow            = (state_reg == ST_RUN);
	assign regular_off_req      = (state_reg == ST_OFF_WAIT) && !fast_reg;
	assign fast_off_req         = (state_reg == ST_OFF_WAIT) && fast_reg;
	assign low_side_on          = low_side_reg;
	assign temp_warning_message = temp_msg_reg;
	assign good_message         = good_msg_reg;
	assign output_good_pin_o    = 1'b0;
	assign output_good_pin_oe   = good_pull_reg;
	assign ok_pin_o             = 1'b0;
	assign ok_pin_oe            = ok_drive_reg;

	// ==================== checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	temp_warn_set_a: assert property (ce && temp_c > TEMP_WARN_ON_C |=> !protection_status_reg[B_TEMP] && temp_warn_reg) else $error("temperature warning not raised");
	temp_hyst_a: assert property (ce && temp_warn_reg && temp_c >= TEMP_WARN_OFF_C |=> temp_warn_reg) else $error("temperature warning left too early");
	good_transition_a: assert property (ce && !steady_state |=> output_good_pin_oe) else $error("good pin released in transition");
	oc_fast_a: assert property (ce && state_reg == ST_RUN && oc_evt && !ov_evt |=> fast_off_req && !run_allow && !low_side_on) else $error("overcurrent not fast off");
	uv_regular_a: assert property (ce && state_reg == ST_RUN && uv_evt && !ot_evt && !tr_evt && !ov_evt |=> regular_off_req && !protection_status_reg[B_UV]) else $error("undervoltage not regular off");
	ov_lowside_a: assert property (ce && state_reg == ST_RUN && ov_evt |=> fast_off_req && low_side_on && !protection_status_reg[B_OV]) else $error("overvoltage low side not on");
	tr_skip_a: assert property (ce && !protection_type_config[B_TRACK_EN] && protection_status_reg[B_TRACK] && !$past(srst) |=> protection_status_reg[B_TRACK]) else $error("tracking tripped while disabled");
	ok_prop_a: assert property (ce && state_reg == ST_RUN && ov_evt && fault_propagation_config[B_OV] |=> ok_pin_oe ##1 (ok_pin_oe || !ce || state_reg == ST_RUN)) else $error("overvoltage not propagated");
	peer_off_a: assert property (ce && state_reg == ST_RUN && ok_ext_low && !any_evt |=> regular_off_req && !ok_pin_oe) else $error("peer shutdown not followed");

	ot_trip_c: cover property (state_reg == ST_RUN && ot_evt ##1 state_reg == ST_OFF_WAIT);
	retry_c: cover property (state_reg == ST_HICCUP && hic.done ##1 state_reg == ST_RUN);
	latched_c: cover property (state_reg == ST_LATCHED ##1 state_reg == ST_RUN);
	peer_c: cover property (state_reg == ST_RUN && ok_ext_low);

endmodule
